// File: umcs_pkg.sv
/*
  Package of the dual-channel modem control and status block: register map,
  field positions, reset values and bit timing.
  Assumes a single 250 MHz system clock and an 8-bit register port.
*/
package umcs_pkg;

  // Timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned BAUD_HZ = 115_200;
  localparam int unsigned BAUD_DIV = CLK_HZ / BAUD_HZ;
  localparam int unsigned FRAME_BITS = 10;

  // Bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // Per-channel offsets; channel b is at CHAN_B_BASE plus these
  localparam logic [7:0] OFS_TX_DATA = 8'h00;
  localparam logic [7:0] OFS_MODEM_CTRL = 8'h04;
  localparam logic [7:0] OFS_MODEM_STATE = 8'h08;
  localparam logic [7:0] OFS_LINE_STATE = 8'h0c;
  localparam logic [7:0] CHAN_A_BASE = 8'h00;
  localparam logic [7:0] CHAN_B_BASE = 8'h10;

  // Shared interrupt registers
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h24;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h28;

  // Field positions
  localparam int unsigned MCR_RTS_BIT = 1;
  localparam int unsigned MCR_LOOP_BIT = 4;
  localparam int unsigned MSR_RING_TRAILING_EDGE_FLAG_BIT = 2;
  localparam int unsigned MSR_RING_BIT = 6;
  localparam int unsigned LSR_BUSY_BIT = 0;
  localparam int unsigned LSR_RX_BIT = 1;
  localparam int unsigned IRQ_RING_A = 0;
  localparam int unsigned IRQ_RING_B = 1;
  localparam int unsigned IRQ_TXD_A = 2;
  localparam int unsigned IRQ_TXD_B = 3;
  localparam int unsigned IRQ_W = 4;

  // Reset values
  localparam logic [IRQ_W-1:0] IRQ_EN_RESET = 4'h0;
  localparam logic [IRQ_W-1:0] IRQ_ST_RESET = 4'h0;
  localparam logic [DATA_W-1:0] RD_DATA_RESET = 8'h00;

endpackage : umcs_pkg

// File: umcs_chan_if.sv
/*
  Interface between the register front end and one serial channel.
  Assumes both ends run on clk_sys; the front end drives the strobes.
*/
`timescale 1ns/1ps
interface umcs_chan_if;
  logic wr_en;
  logic rd_en;
  logic [1:0] idx;
  logic [7:0] wdata;
  logic ring_trailing_edge_flag_clr;
  logic [7:0] rdata;
  logic ring_trailing_edge_flag;
  logic tx_done;

  modport top (output wr_en, output rd_en, output idx, output wdata, output ring_trailing_edge_flag_clr,
               input rdata, input ring_trailing_edge_flag, input tx_done);
  modport chan (input wr_en, input rd_en, input idx, input wdata, input ring_trailing_edge_flag_clr,
                output rdata, output ring_trailing_edge_flag, output tx_done);
endinterface : umcs_chan_if

// File: umcs_chan.sv
/*
  One serial channel: ring detection, trailing-edge flag, request-to-send,
  loop mode and an 8N1 transmitter.
  Assumes an active-low reset that asserts at once and is released on clk_sys,
  and one-cycle strobes from the front end.
*/
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module umcs_chan #(
  parameter int unsigned BAUD_DIV = umcs_pkg::BAUD_DIV
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  umcs_chan_if.chan bus,
  input wire logic ring_in_n,
  input wire logic rx_in,
  output logic tx_out,
  output logic rts_out_n
);
  import umcs_pkg::*;

  localparam logic [15:0] BAUD_LAST = 16'(BAUD_DIV - 1);
  localparam logic [3:0] FRAME_LAST = 4'(FRAME_BITS - 1);
  localparam logic [1:0] IDX_TX = OFS_TX_DATA[3:2];
  localparam logic [1:0] IDX_MCR = OFS_MODEM_CTRL[3:2];
  localparam logic [1:0] IDX_MSR = OFS_MODEM_STATE[3:2];
  localparam logic [1:0] IDX_LSR = OFS_LINE_STATE[3:2];

  typedef struct packed {
    logic ri_m;
    logic ri_s;
    logic ri_prev;
    logic rx_m;
    logic rx_s;
    logic ring_trailing_edge_flag;
    logic rts;
    logic loop;
    logic busy;
    logic [9:0] shift;
    logic [3:0] bits;
    logic [15:0] baud;
    logic tx;
    logic rts_n;
    logic done;
  } umcs_chan_st_t;

  umcs_chan_st_t q, d;
  logic ring_rise;
  logic tx_line;

  // Edge of the synchronised ring pin and the internal line level
  assign ring_rise = q.ri_s && !q.ri_prev;
  assign tx_line = q.busy ? q.shift[0] : 1'b1;

  // Next-state logic
  always_comb begin
    d = q;
    d.ri_m = ring_in_n;
    d.ri_s = q.ri_m;
    d.ri_prev = q.ri_s;
    d.rx_m = rx_in;
    d.rx_s = q.rx_m;
    d.done = 1'b0;
    // Status read or interrupt clear drops the flag; a new edge wins
    if ((bus.rd_en && bus.idx == IDX_MSR) || bus.ring_trailing_edge_flag_clr) begin
      d.ring_trailing_edge_flag = 1'b0; // RQ12
    end
    if (ring_rise) begin
      d.ring_trailing_edge_flag = 1'b1; // RQ3
    end
    // Modem control write
    if (bus.wr_en && bus.idx == IDX_MCR) begin
      d.rts = bus.wdata[MCR_RTS_BIT];
      d.loop = bus.wdata[MCR_LOOP_BIT];
    end
    // Transmitter: start, data, stop; writes while busy are dropped
    if (q.busy) begin
      if (q.baud == BAUD_LAST) begin
        d.baud = 16'h0000;
        d.shift = {1'b1, q.shift[9:1]};
        if (q.bits == FRAME_LAST) begin
          d.busy = 1'b0;
          d.bits = 4'h0;
          d.done = 1'b1;
        end else begin
          d.bits = q.bits + 4'h1;
        end
      end else begin
        d.baud = q.baud + 16'h0001;
      end
    end else if (bus.wr_en && bus.idx == IDX_TX) begin
      d.busy = 1'b1; // RQ10
      d.shift = {1'b1, bus.wdata, 1'b0};
      d.baud = 16'h0000;
      d.bits = 4'h0;
    end
    // Pins: loop mode holds both lines inactive
    d.tx = d.loop ? 1'b1 : (d.busy ? d.shift[0] : 1'b1); // RQ9
    d.rts_n = !(d.rts && !d.loop); // RQ5 RQ6 RQ8
  end

  // State register; reset leaves the lines marking and inactive
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.ri_m <= 1'b1;
      q.ri_s <= 1'b1;
      q.ri_prev <= 1'b1;
      q.rx_m <= 1'b1;
      q.rx_s <= 1'b1;
      q.shift <= 10'h3ff;
      q.tx <= 1'b1; // RQ9
      q.rts_n <= 1'b1; // RQ7
    end else begin
      q <= d;
    end
  end

  // Read value of the addressed register
  always_comb begin
    bus.rdata = 8'h00;
    case (bus.idx)
      IDX_MCR: begin
        bus.rdata[MCR_RTS_BIT] = q.rts;
        bus.rdata[MCR_LOOP_BIT] = q.loop;
      end
      IDX_MSR: begin
        bus.rdata[MSR_RING_BIT] = !q.ri_s; // RQ2
        bus.rdata[MSR_RING_TRAILING_EDGE_FLAG_BIT] = q.ring_trailing_edge_flag;
      end
      IDX_LSR: begin
        bus.rdata[LSR_BUSY_BIT] = q.busy;
        bus.rdata[LSR_RX_BIT] = q.loop ? tx_line : q.rx_s; // RQ11
      end
      default: begin
        bus.rdata = 8'h00;
      end
    endcase
  end

  assign bus.ring_trailing_edge_flag = q.ring_trailing_edge_flag;
  assign bus.tx_done = q.done;
  assign tx_out = q.tx;
  assign rts_out_n = q.rts_n;

  // Checks on the channel's own outputs
  sequence ring_edge_s;
    q.ri_s && !q.ri_prev;
  endsequence
  sequence tx_start_s;
    bus.wr_en && bus.idx == IDX_TX && !q.busy && !q.loop;
  endsequence

  ring_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ2
    (bus.idx == IDX_MSR && $past(rst_n, 3)) |-> bus.rdata[MSR_RING_BIT] == !$past(ring_in_n, 2))
    else $error("ring state bit does not invert the pin");
  ring_trailing_edge_flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
    ring_edge_s |=> q.ring_trailing_edge_flag)
    else $error("trailing edge flag not set");
  ring_trailing_edge_flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ12
    (bus.rd_en && bus.idx == IDX_MSR && !ring_rise) |=> !q.ring_trailing_edge_flag)
    else $error("trailing edge flag not cleared by read");
  rts_level_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
    (q.rts && !q.loop) |-> !rts_out_n)
    else $error("request to send not active");
  rts_loop_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ8
    q.loop |-> rts_out_n && tx_out)
    else $error("loop mode lines not inactive");
  tx_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ9
    !q.busy |-> tx_out)
    else $error("idle transmit line not marking");
  frame_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
    tx_start_s ##1 !bus.wr_en [*2] |-> !tx_out && q.busy)
    else $error("start bit missing");
  stop_bit_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
    q.done |-> tx_out && !q.busy)
    else $error("frame did not end marking");

endmodule : umcs_chan

// File: umcs_top.sv
/*
  Top of the dual-channel modem control and status block: reset release,
  register port decode, shared interrupt registers and two channels.
  Assumes a plain strobe register port on clk_sys and asynchronous pins.
*/
`timescale 1ns/1ps
// Functional notes
// RQ1: The modem pulls ring-indicate low when a telephone ring arrives.
// RQ2: Modem state bit 6 reads the inverse of the ring-indicate pin.
// RQ3: Modem state bit 2 sets when ring-indicate rose since the last read.
// RQ4: Trailing-edge flag with modem interrupt enabled raises the interrupt.
// RQ5: Control bit 1 set drives request-to-send low.
// RQ6: Active request-to-send tells the modem the channel is ready.
// RQ7: Reset forces request-to-send high, inactive.
// RQ8: Loop mode holds request-to-send inactive regardless of the control bit.
// RQ9: After reset the transmit line rests marking, at one.
// RQ10: Each channel shifts serial frames out on its transmit line.
// RQ11: The modem supplies serial data on each receive line.
// RQ12: Reading the modem state register clears the trailing-edge flag.
module umcs_top #(
  parameter int unsigned BAUD_DIV = umcs_pkg::BAUD_DIV
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [umcs_pkg::ADDR_W-1:0] addr,
  input wire logic [umcs_pkg::DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [umcs_pkg::DATA_W-1:0] rd_data,
  output logic irq,
  input wire logic ring_indicate_in_a_n,
  input wire logic ring_indicate_in_b_n,
  input wire logic serial_rx_in_a,
  input wire logic serial_rx_in_b,
  output logic serial_tx_out_a,
  output logic serial_tx_out_b,
  output logic request_send_out_a_n,
  output logic request_send_out_b_n
);
  import umcs_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] rd_data;
    logic [IRQ_W-1:0] irq_st;
    logic [IRQ_W-1:0] irq_en;
    logic irq;
  } umcs_top_st_t;

  umcs_top_st_t q, d;
  logic rst_m;
  logic rst_n;
  logic sel_a;
  logic sel_b;
  logic [IRQ_W-1:0] status_now;

  umcs_chan_if ch_a();
  umcs_chan_if ch_b();

  // Word-aligned hit on a 16-byte channel window
  function automatic logic chan_hit(input logic [7:0] a, input logic [7:0] base);
    chan_hit = (a[7:4] == base[7:4]) && (a[1:0] == 2'b00);
  endfunction : chan_hit

  // Reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_m <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_n <= rst_m;
    end
  end

  // Channel selection and strobes
  assign sel_a = chan_hit(addr, CHAN_A_BASE);
  assign sel_b = chan_hit(addr, CHAN_B_BASE);
  assign ch_a.wr_en = wr_en && sel_a;
  assign ch_a.rd_en = rd_en && sel_a;
  assign ch_a.idx = addr[3:2];
  assign ch_a.wdata = wr_data;
  assign ch_b.wr_en = wr_en && sel_b;
  assign ch_b.rd_en = rd_en && sel_b;
  assign ch_b.idx = addr[3:2];
  assign ch_b.wdata = wr_data;

  // Clearing a ring bit also drops the channel's trailing-edge flag
  assign ch_a.ring_trailing_edge_flag_clr = wr_en && addr == OFS_IRQ_CLEAR && wr_data[IRQ_RING_A];
  assign ch_b.ring_trailing_edge_flag_clr = wr_en && addr == OFS_IRQ_CLEAR && wr_data[IRQ_RING_B];

  // Ring bits mirror the flags; transmit-done bits are sticky
  always_comb begin
    status_now = q.irq_st;
    status_now[IRQ_RING_A] = ch_a.ring_trailing_edge_flag;
    status_now[IRQ_RING_B] = ch_b.ring_trailing_edge_flag;
  end

  // Next-state logic of the front end
  always_comb begin
    d = q;
    d.rd_data = RD_DATA_RESET;
    if (rd_en) begin
      if (sel_a) begin
        d.rd_data = ch_a.rdata;
      end else if (sel_b) begin
        d.rd_data = ch_b.rdata;
      end else if (addr == OFS_IRQ_STATUS) begin
        d.rd_data = {4'h0, status_now};
      end else if (addr == OFS_IRQ_ENABLE) begin
        d.rd_data = {4'h0, q.irq_en};
      end
    end
    if (wr_en && addr == OFS_IRQ_ENABLE) begin
      d.irq_en = wr_data[IRQ_W-1:0];
    end
    // Clear first, then a new completion wins
    if (wr_en && addr == OFS_IRQ_CLEAR) begin
      d.irq_st = q.irq_st & ~wr_data[IRQ_W-1:0];
    end
    if (ch_a.tx_done) begin
      d.irq_st[IRQ_TXD_A] = 1'b1;
    end
    if (ch_b.tx_done) begin
      d.irq_st[IRQ_TXD_B] = 1'b1;
    end
    d.irq_st[IRQ_RING_A] = 1'b0;
    d.irq_st[IRQ_RING_B] = 1'b0;
    // Level interrupt while any enabled event stands
    d.irq = |(status_now & q.irq_en); // RQ4
  end

  // Front-end state register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q.rd_data <= RD_DATA_RESET;
      q.irq_st <= IRQ_ST_RESET;
      q.irq_en <= IRQ_EN_RESET;
      q.irq <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign rd_data = q.rd_data;
  assign irq = q.irq;

  // Channel a
  umcs_chan #(.BAUD_DIV(BAUD_DIV)) u_chan_a (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(ch_a),
    .ring_in_n(ring_indicate_in_a_n), // RQ1
    .rx_in(serial_rx_in_a),
    .tx_out(serial_tx_out_a),
    .rts_out_n(request_send_out_a_n)
  );

  // Channel b
  umcs_chan #(.BAUD_DIV(BAUD_DIV)) u_chan_b (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .bus(ch_b),
    .ring_in_n(ring_indicate_in_b_n), // RQ1
    .rx_in(serial_rx_in_b),
    .tx_out(serial_tx_out_b),
    .rts_out_n(request_send_out_b_n)
  );

  // Checks on the front end
  irq_raise_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ4
    (ch_a.ring_trailing_edge_flag && q.irq_en[IRQ_RING_A]) |=> irq)
    else $error("ring interrupt not raised");
  irq_quiet_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ4
    ((status_now & q.irq_en) == 4'h0) |=> !irq)
    else $error("interrupt without enabled event");
  rd_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !rd_en |=> rd_data == RD_DATA_RESET)
    else $error("read data outside its cycle");

endmodule : umcs_top

// File: umcs_modem_model.sv
/*
  Modem model for both channels: drives the ring lines and receive lines,
  and captures the byte framed on channel a's transmit line.
  Assumes 8N1 framing at BAUD_DIV clk_sys cycles per bit.
*/
`timescale 1ns/1ps
module umcs_modem_model #(
  parameter int unsigned BAUD_DIV = 4
) (
  input wire logic clk_sys,
  input wire logic [1:0] ring_on,
  input wire logic [1:0] tx_line,
  input wire logic [1:0] rts_line_n,
  output logic [1:0] ring_line_n,
  output logic [1:0] rx_line,
  output logic [7:0] rx_byte_a
);
  // A ring pulls the line low
  assign ring_line_n = ~ring_on;
  // Data only flows back while the channel asks for it, else the line marks
  assign rx_line = rts_line_n | tx_line;

  // Samples each data bit near its middle, LSB first
  initial begin
    rx_byte_a = 8'h00;
    forever begin
      @(negedge tx_line[0]);
      repeat (BAUD_DIV / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
        repeat (BAUD_DIV) @(posedge clk_sys);
        rx_byte_a[i] = tx_line[0];
      end
      repeat (BAUD_DIV) @(posedge clk_sys);
    end
  end
endmodule : umcs_modem_model

// File: umcs_top_tb.sv
/*
  Self-checking bench of the modem control and status block.
  Assumes the register map of the package and a short bit time.
*/
`timescale 1ns/1ps
module umcs_top_tb;
  import umcs_pkg::*;
  localparam int unsigned DIV = 4;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [1:0] ring_on = 2'h0;
  logic [7:0] rd_data;
  logic irq;
  logic [1:0] ring_n, rx, tx, rts_n;
  logic [7:0] cap, d, base;
  int n_errors = 0;
  int samples_checked = 0;
  int k;

  // Clock, 4 ns period
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end

  umcs_top #(.BAUD_DIV(DIV)) DUT (.clk_sys(clk_sys), .resetn(resetn), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq),
    .ring_indicate_in_a_n(ring_n[0]), .ring_indicate_in_b_n(ring_n[1]),
    .serial_rx_in_a(rx[0]), .serial_rx_in_b(rx[1]),
    .serial_tx_out_a(tx[0]), .serial_tx_out_b(tx[1]),
    .request_send_out_a_n(rts_n[0]), .request_send_out_b_n(rts_n[1]));

  umcs_modem_model #(.BAUD_DIV(DIV)) modem (.clk_sys(clk_sys), .ring_on(ring_on),
    .tx_line(tx), .rts_line_n(rts_n), .ring_line_n(ring_n), .rx_line(rx),
    .rx_byte_a(cap));

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr

  // Read data is taken at the edge that closes the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(posedge clk_sys);
    v = rd_data;
  endtask : rd

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic pin(input int ch, input logic v);
    @(posedge clk_sys);
    ring_on[ch] <= v;
  endtask : pin

  task automatic final_report;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  // Main sequence; a timed-out wait leaves the named block for the report
  initial begin
    begin : run_seq
      cyc(12);
      resetn <= 1'b1;
      cyc(3);
      chk({6'h0, tx}, 8'h03);
      chk({6'h0, rts_n}, 8'h03);
      chk({7'h0, irq}, 8'h00);
      // Request-to-send per channel, with loop mode overriding it
      for (int ch = 0; ch < 2; ch++) begin
        base = ch[0] ? CHAN_B_BASE : CHAN_A_BASE;
        wr(base + OFS_MODEM_CTRL, 8'h02);
        cyc(2);
        chk({6'h0, rts_n}, ch[0] ? 8'h01 : 8'h02);
        wr(base + OFS_MODEM_CTRL, 8'h12);
        cyc(2);
        chk({6'h0, rts_n}, 8'h03);
        wr(base + OFS_MODEM_CTRL, 8'h00);
      end
      // Ring state, trailing edge, interrupt, read clear, masked flag
      for (int ch = 0; ch < 2; ch++) begin
        base = ch[0] ? CHAN_B_BASE : CHAN_A_BASE;
        wr(OFS_IRQ_ENABLE, 8'h01 << ch);
        pin(ch, 1'b1);
        cyc(5);
        rd(base + OFS_MODEM_STATE, d);
        chk(d & 8'h44, 8'h40);
        pin(ch, 1'b0);
        cyc(6);
        chk({7'h0, irq}, 8'h01);
        rd(base + OFS_MODEM_STATE, d);
        chk(d & 8'h44, 8'h04);
        cyc(3);
        chk({7'h0, irq}, 8'h00);
        rd(base + OFS_MODEM_STATE, d);
        chk(d & 8'h44, 8'h00);
        wr(OFS_IRQ_ENABLE, 8'h00);
        pin(ch, 1'b1);
        pin(ch, 1'b0);
        cyc(6);
        chk({7'h0, irq}, 8'h00);
        rd(OFS_IRQ_STATUS, d);
        chk(d & 8'h03, 8'h01 << ch);
        wr(OFS_IRQ_CLEAR, 8'h01 << ch);
        rd(OFS_IRQ_STATUS, d);
        chk(d & 8'h03, 8'h00);
      end
      // Frame on channel a while request-to-send is active
      wr(CHAN_A_BASE + OFS_MODEM_CTRL, 8'h02);
      wr(OFS_IRQ_ENABLE, 8'h04);
      wr(CHAN_A_BASE + OFS_TX_DATA, 8'ha5);
      k = 0;
      while (irq !== 1'b1 && k < 20 * DIV) begin
        cyc(1);
        k++;
      end
      if (k >= 20 * DIV) begin
        n_errors++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        disable run_seq;
      end
      chk(cap, 8'ha5);
      chk({7'h0, tx[0]}, 8'h01);
      rd(CHAN_A_BASE + OFS_LINE_STATE, d);
      chk(d & 8'h03, 8'h02);
      wr(OFS_IRQ_CLEAR, 8'h04);
      wr(OFS_IRQ_ENABLE, 8'h00);
      rd(8'h30, d);
      chk(d, 8'h00);
      // Loop mode on channel b: the frame runs inside, the pins stay inactive
      wr(CHAN_B_BASE + OFS_MODEM_CTRL, 8'h10);
      rd(CHAN_B_BASE + OFS_MODEM_CTRL, d);
      chk(d, 8'h10);
      wr(CHAN_B_BASE + OFS_TX_DATA, 8'h5a);
      rd(CHAN_B_BASE + OFS_LINE_STATE, d);
      chk(d & 8'h03, 8'h01);
      chk({6'h0, tx[1], rts_n[1]}, 8'h03);
      cyc(12 * DIV);
      rd(OFS_IRQ_STATUS, d);
      chk(d & 8'h0c, 8'h08);
      chk({7'h0, irq}, 8'h00);
      wr(OFS_IRQ_CLEAR, 8'h08);
      wr(CHAN_B_BASE + OFS_MODEM_CTRL, 8'h00);
      // Mid-run reset returns the pins to rest, then control reads cleared
      resetn <= 1'b0;
      cyc(2);
      chk({4'h0, tx, rts_n}, 8'h0f);
      resetn <= 1'b1;
      cyc(3);
      chk({4'h0, tx, rts_n}, 8'h0f);
      rd(CHAN_A_BASE + OFS_MODEM_CTRL, d);
      chk(d, 8'h00);
    end : run_seq
    final_report();
  end
endmodule : umcs_top_tb
